/* File: hw/gdio_consts.svh */
// Constants of the general digital I/O port: widths, reset values and timing
`ifndef GDIO_CONSTS_SVH
`define GDIO_CONSTS_SVH

// ==========================================================================
// Geometry
`define GDIO_PORT_WIDTH       8

// ==========================================================================
// Reset values
`define GDIO_LATCH_RESET      8'h00
`define GDIO_DIR_RESET        8'h00
`define GDIO_RDATA_RESET      8'h00

// ==========================================================================
// Timing
`define GDIO_CLK_PERIOD_NS    10
`define GDIO_SYNC_DELAY_PS    1000
`define GDIO_SYNC_CYCLES      ((`GDIO_SYNC_DELAY_PS + `GDIO_CLK_PERIOD_NS * 100 - 1) / (`GDIO_CLK_PERIOD_NS * 100))

`endif

/* File: hw/gdio_pkg.sv */
// Types shared by the general digital I/O port
`default_nettype none

package gdio_pkg;

    // ======================================================================
    // Source of the registered read data
    typedef enum logic [1:0] {
        GDIO_SEL_NONE  = 2'b00,
        GDIO_SEL_LATCH = 2'b01,
        GDIO_SEL_DIR   = 2'b10,
        GDIO_SEL_PIN   = 2'b11
    } gdio_rd_sel_t;

endpackage : gdio_pkg

`default_nettype wire

/* File: hw/gdio_pin_sync.sv */
// Pin input synchronizer: falling-edge capture stage, then rising-edge register
`timescale 1ns/100ps
`default_nettype none

module gdio_pin_sync #(
    parameter int WIDTH = 8
) (
    input  wire logic             clk,
    input  wire logic             nrst,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);

    // ======================================================================
    // Stages
    logic [WIDTH-1:0] hold_reg;
    logic [WIDTH-1:0] hold_next;
    logic [WIDTH-1:0] q_reg;
    logic [WIDTH-1:0] q_next;

    // Capture stage stands in for a latch open while the clock is high:
    // it freezes the pin on the falling edge, read only by the next stage
    always_comb begin
        hold_next = d;
        q_next    = hold_reg;
    end

    always_ff @(negedge clk or negedge nrst) begin
        if (!nrst) begin
            hold_reg <= '0;
        end else begin
            hold_reg <= hold_next;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            q_reg <= '0;
        end else begin
            q_reg <= q_next;
        end
    end

    assign q = q_reg;

endmodule : gdio_pin_sync

`default_nettype wire

/* File: hw/gdio_port.sv */
// General digital I/O port: latch, direction and input registers with pin control
`timescale 1ns/100ps
`default_nettype none
`include "gdio_consts.svh"

module gdio_port
    import gdio_pkg::*;
#(
    parameter int WIDTH = `GDIO_PORT_WIDTH
) (
    input  wire logic             CLK,
    input  wire logic             NRST,
    input  wire logic [WIDTH-1:0] WDATA,
    input  wire logic [WIDTH-1:0] BIT_MASK,
    input  wire logic             LATCH_WRITE_STROBE,
    input  wire logic             DIRECTION_WRITE_STROBE,
    input  wire logic             TOGGLE_WRITE_STROBE,
    input  wire logic             LATCH_READ_STROBE,
    input  wire logic             DIRECTION_READ_STROBE,
    input  wire logic             PIN_READ_STROBE,
    output logic      [WIDTH-1:0] RDATA,
    input  wire logic             GLOBAL_PULLUP_DISABLE,
    input  wire logic [WIDTH-1:0] ALT_OVERRIDE_EN,
    input  wire logic [WIDTH-1:0] ALT_OUT_EN,
    input  wire logic [WIDTH-1:0] ALT_OUT_VAL,
    input  wire logic [WIDTH-1:0] PIN_IN,
    output logic      [WIDTH-1:0] PIN_OUT,
    output logic      [WIDTH-1:0] PIN_OE,
    output logic      [WIDTH-1:0] PIN_PULLUP
);

    // ======================================================================
    // Register state
    logic [WIDTH-1:0] port_output_latch_reg;
    logic [WIDTH-1:0] port_output_latch_next;
    logic [WIDTH-1:0] port_direction_reg;
    logic [WIDTH-1:0] port_direction_next;
    logic [WIDTH-1:0] rdata_reg;
    logic [WIDTH-1:0] rdata_next;
    logic [WIDTH-1:0] port_pin_input;
    gdio_rd_sel_t     rd_sel;

    // ======================================================================
    // Input synchronizer
    gdio_pin_sync #(
        .WIDTH (WIDTH)
    ) u_sync (
        .clk  (CLK),
        .nrst (NRST),
        .d    (PIN_IN),
        .q    (port_pin_input)
    );

    // ======================================================================
    // Register writes; the mask lets bit set/clear touch one pin only
    always_comb begin
        port_output_latch_next = port_output_latch_reg;
        port_direction_next    = port_direction_reg;
        if (LATCH_WRITE_STROBE) begin
            port_output_latch_next = (port_output_latch_reg & ~BIT_MASK) | (WDATA & BIT_MASK);
        end
        if (DIRECTION_WRITE_STROBE) begin
            port_direction_next = (port_direction_reg & ~BIT_MASK) | (WDATA & BIT_MASK);
        end
        if (TOGGLE_WRITE_STROBE) begin
            port_output_latch_next = port_output_latch_next ^ (WDATA & BIT_MASK);
        end
    end

    // ======================================================================
    // Registered read data; one read strobe is expected at a time
    always_comb begin
        if (LATCH_READ_STROBE) begin
            rd_sel = GDIO_SEL_LATCH;
        end else if (DIRECTION_READ_STROBE) begin
            rd_sel = GDIO_SEL_DIR;
        end else if (PIN_READ_STROBE) begin
            rd_sel = GDIO_SEL_PIN;
        end else begin
            rd_sel = GDIO_SEL_NONE;
        end
        case (rd_sel)
            GDIO_SEL_LATCH: rdata_next = port_output_latch_reg;
            GDIO_SEL_DIR:   rdata_next = port_direction_reg;
            GDIO_SEL_PIN:   rdata_next = port_pin_input;
            default:        rdata_next = rdata_reg;
        endcase
    end

    // Asynchronous reset clears direction, so pins float with no clock unless ALT_OVERRIDE_EN and ALT_OUT_EN drive them
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            port_output_latch_reg <= WIDTH'(`GDIO_LATCH_RESET);
            port_direction_reg    <= WIDTH'(`GDIO_DIR_RESET);
            rdata_reg             <= WIDTH'(`GDIO_RDATA_RESET);
        end else begin
            port_output_latch_reg <= port_output_latch_next;
            port_direction_reg    <= port_direction_next;
            rdata_reg             <= rdata_next;
        end
    end

    // ======================================================================
    // Pin control; overrides act per pin, leaving the rest plain I/O
    logic [WIDTH-1:0] eff_dir;
    logic [WIDTH-1:0] eff_val;

    assign eff_dir    = (ALT_OVERRIDE_EN & ALT_OUT_EN) | (~ALT_OVERRIDE_EN & port_direction_reg);
    assign eff_val    = (ALT_OVERRIDE_EN & ALT_OUT_VAL) | (~ALT_OVERRIDE_EN & port_output_latch_reg);
    assign PIN_OE     = eff_dir;
    assign PIN_OUT    = eff_val;
    assign PIN_PULLUP = ~eff_dir & port_output_latch_reg & {WIDTH{~GLOBAL_PULLUP_DISABLE}};
    assign RDATA      = rdata_reg;

    // ======================================================================
    // Assertions
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!NRST);

    property p_dir_write;
        DIRECTION_WRITE_STROBE |-> ##1
            (((PIN_OE ^ $past(WDATA)) & $past(BIT_MASK) & ~ALT_OVERRIDE_EN & ~$past(ALT_OVERRIDE_EN)) == '0);
    endproperty
    a_dir_write: assert property (p_dir_write) else $error("direction write not seen on output enable");

    property p_pullup_off;
        ((PIN_PULLUP & (PIN_OE | ~port_output_latch_reg)) == '0);
    endproperty
    a_pullup_off: assert property (p_pullup_off) else $error("pull-up on for output or zero latch");

    // Only input pins are compared, since an output pin never carries a pull-up
    property p_pullup_on;
        (LATCH_WRITE_STROBE && !TOGGLE_WRITE_STROBE && !DIRECTION_WRITE_STROBE
            && !GLOBAL_PULLUP_DISABLE)
        |-> ##1 (GLOBAL_PULLUP_DISABLE
            || (((PIN_PULLUP ^ $past(WDATA)) & $past(BIT_MASK) & ~PIN_OE) == '0));
    endproperty
    a_pullup_on: assert property (p_pullup_on) else $error("pull-up does not follow latch on input pin");

    property p_reset_tristate;
        @(posedge CLK) disable iff (1'b0) !NRST |-> (PIN_OE == '0) && (port_output_latch_reg == '0);
    endproperty
    a_reset_tristate: assert property (p_reset_tristate) else $error("pin driven during reset");

    property p_out_drive;
        (LATCH_WRITE_STROBE && !TOGGLE_WRITE_STROBE) |-> ##1
            (((PIN_OUT ^ $past(WDATA)) & $past(BIT_MASK) & ~ALT_OVERRIDE_EN & ~$past(ALT_OVERRIDE_EN)) == '0);
    endproperty
    a_out_drive: assert property (p_out_drive) else $error("output value does not follow latch write");

    property p_toggle;
        (TOGGLE_WRITE_STROBE && !LATCH_WRITE_STROBE) |-> ##1
            (port_output_latch_reg == ($past(port_output_latch_reg) ^ ($past(WDATA) & $past(BIT_MASK))));
    endproperty
    a_toggle: assert property (p_toggle) else $error("toggle write gave wrong latch value");

    property p_read_back;
        LATCH_READ_STROBE |-> ##1 (RDATA == $past(port_output_latch_reg));
    endproperty
    a_read_back: assert property (p_read_back) else $error("latch read returned wrong data");

    property p_global_disable;
        GLOBAL_PULLUP_DISABLE |-> (PIN_PULLUP == '0);
    endproperty
    a_global_disable: assert property (p_global_disable) else $error("pull-up on while globally disabled");

    property p_single_bit;
        (LATCH_WRITE_STROBE || DIRECTION_WRITE_STROBE || TOGGLE_WRITE_STROBE) |-> ##1
            ((((port_output_latch_reg ^ $past(port_output_latch_reg))
              | (port_direction_reg ^ $past(port_direction_reg))) & ~$past(BIT_MASK)) == '0);
    endproperty
    a_single_bit: assert property (p_single_bit) else $error("unaddressed bit changed");

    property p_sync_delay;
        ((PIN_IN == $past(PIN_IN)) && ($past(PIN_IN) == $past(PIN_IN, 2))) |-> (port_pin_input == $past(PIN_IN));
    endproperty
    a_sync_delay: assert property (p_sync_delay) else $error("input register lags a stable pin");

    // Pin data is the synchronised level, handed over one read cycle late
    property p_pin_read;
        (PIN_READ_STROBE && !LATCH_READ_STROBE && !DIRECTION_READ_STROBE) |-> ##1
            (RDATA == $past(port_pin_input));
    endproperty
    a_pin_read: assert property (p_pin_read) else $error("pin read returned wrong data");

    property p_dir_read;
        (DIRECTION_READ_STROBE && !LATCH_READ_STROBE) |-> ##1 (RDATA == $past(port_direction_reg));
    endproperty
    a_dir_read: assert property (p_dir_read) else $error("direction read returned wrong data");

    // Read data stands between reads, so a slow reader still sees what it asked for
    property p_rdata_hold;
        !(LATCH_READ_STROBE || DIRECTION_READ_STROBE || PIN_READ_STROBE) |-> ##1 $stable(RDATA);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data changed without a read");

    // Main scenarios: toggle, pull-up, pin read, loop-back read, output drive
    c_toggle:    cover property (TOGGLE_WRITE_STROBE ##1 $changed(port_output_latch_reg));
    c_pullup:    cover property ($rose(PIN_PULLUP[0]));
    c_pin_read:  cover property (PIN_READ_STROBE ##1 (RDATA != '0));
    c_loop_read: cover property (LATCH_WRITE_STROBE ##2 PIN_READ_STROBE);
    c_dir_out:   cover property ($rose(PIN_OE[7]));

endmodule : gdio_port

`default_nettype wire

/* File: verif/gdio_pad_model.sv */
// Pad model: resolves each pin from device drive, outside driver and pull-up
`timescale 1ns/100ps
`default_nettype none

module gdio_pad_model #(
    parameter int WIDTH = 8
) (
    input  wire logic             clk,
    input  wire logic [WIDTH-1:0] pin_out,
    input  wire logic [WIDTH-1:0] pin_oe,
    input  wire logic [WIDTH-1:0] pin_pullup,
    input  wire logic [WIDTH-1:0] ext_en,
    input  wire logic [WIDTH-1:0] ext_val,
    output logic      [WIDTH-1:0] pad
);
    logic [WIDTH-1:0] float_reg = '0;
    // A floating pin wanders every cycle so a stale level never passes for a read
    always @(posedge clk) float_reg <= ~float_reg;
    assign pad = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val) | (~pin_oe & ~ext_en & pin_pullup)
               | (~pin_oe & ~ext_en & ~pin_pullup & float_reg);
endmodule : gdio_pad_model
`default_nettype wire

/* File: verif/tb.sv */
// Self-checking testbench of the general digital I/O port
`timescale 1ns/100ps
`default_nettype none

module tb;
    logic       clk = 1'b0;
    logic       nrst = 1'b0;
    logic       global_pullup_disable = 1'b0;
    logic [7:0] wd = 8'h00, msk = 8'h00, alt_en = 8'h00, alt_oe = 8'h00, alt_v = 8'h00;
    logic [7:0] ext_en = 8'h00, ext_v = 8'h00;
    logic [2:0] wstb = 3'h0;
    logic [2:0] rstb = 3'h0;
    logic [7:0] rdata, p_out, p_oe, p_pu, pad, v;
    int         fails = 0;
    int         total_checks = 0;

    always #5 clk = ~clk;

    gdio_port #(.WIDTH(8)) i_dut (.CLK(clk), .NRST(nrst), .WDATA(wd), .BIT_MASK(msk),
        .LATCH_WRITE_STROBE(wstb[0]), .DIRECTION_WRITE_STROBE(wstb[1]), .TOGGLE_WRITE_STROBE(wstb[2]),
        .LATCH_READ_STROBE(rstb[0]), .DIRECTION_READ_STROBE(rstb[1]), .PIN_READ_STROBE(rstb[2]),
        .RDATA(rdata), .GLOBAL_PULLUP_DISABLE(global_pullup_disable), .ALT_OVERRIDE_EN(alt_en), .ALT_OUT_EN(alt_oe),
        .ALT_OUT_VAL(alt_v), .PIN_IN(pad), .PIN_OUT(p_out), .PIN_OE(p_oe), .PIN_PULLUP(p_pu));
    gdio_pad_model #(.WIDTH(8)) i_pads (.clk(clk), .pin_out(p_out), .pin_oe(p_oe), .pin_pullup(p_pu),
        .ext_en(ext_en), .ext_val(ext_v), .pad(pad));

    // ======================================================================
    // Bus tasks; wr and rd are entered and left at a falling edge, check at any time
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %0t: got %h, want %h", $time, seen, exp);
        end
    endtask : check

    // One idle cycle after each strobe so a strobe is never set twice in one step
    task automatic wr(input int s, input logic [7:0] d, input logic [7:0] m);
        wd = d;
        msk = m;
        wstb[s] = 1'b1;
        @(negedge clk);
        wstb = 3'h0;
        @(negedge clk);
    endtask : wr

    task automatic rd(input int s, output logic [7:0] r);
        rstb[s] = 1'b1;
        @(negedge clk);
        rstb = 3'h0;
        r = rdata;
        @(negedge clk);
    endtask : rd

    // Latch first keeps every pin clear of the forbidden direct hops
    task automatic cfg(input logic [7:0] d, input logic [7:0] l);
        wr(0, l, 8'hFF);
        wr(1, d, 8'hFF);
    endtask : cfg

    task automatic test_done;
        $display("Checks %0d, mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : test_done

    // ======================================================================
    // Scenarios
    task automatic t_reset;
        check(p_oe, 8'h00);
        check(p_pu, 8'h00);
        nrst = 1'b1;
        @(negedge clk);
        rd(0, v);
        check(v, 8'h00);
        rd(1, v);
        check(v, 8'h00);
    endtask : t_reset

    task automatic t_table;
        logic [7:0] d, l, pu;
        for (int i = 0; i < 4; i++) begin
            global_pullup_disable = i[0];
            d = i[1] ? 8'h33 : 8'hCC;
            l = i[1] ? 8'h55 : 8'hAA;
            pu = ~d & l & {8{~global_pullup_disable}};
            ext_en = ~d & ~pu;
            ext_v = 8'h69;
            cfg(d, l);
            check(p_oe, d);
            check(p_out & d, l & d);
            check(p_pu, pu);
            rd(2, v);
            check(v, (d & l) | pu | (ext_en & 8'h69));
            rd(1, v);
            check(v, d);
        end
        global_pullup_disable = 1'b0;
    endtask : t_table

    task automatic t_toggle;
        cfg(8'hF0, 8'hA5);
        wr(2, 8'h0F, 8'hFF);
        rd(0, v);
        check(v, 8'hAA);
        wr(2, 8'h00, 8'hFF);
        rd(0, v);
        check(v, 8'hAA);
        // Latch write and toggle together: the toggle acts on the written value
        wd = 8'h0F;
        msk = 8'h0F;
        wstb = 3'b101;
        @(negedge clk);
        wstb = 3'h0;
        @(negedge clk);
        rd(0, v);
        check(v, 8'hA0);
        wr(2, 8'h10, 8'hFF);
        check(p_out & 8'hF0, 8'hB0);
    endtask : t_toggle

    task automatic t_bits;
        cfg(8'h5A, 8'h3C);
        wr(1, 8'hFF, 8'h01);
        wr(0, 8'h00, 8'h04);
        rd(1, v);
        check(v, 8'h5B);
        rd(0, v);
        check(v, 8'h38);
        check(p_pu, 8'h20);
    endtask : t_bits

    task automatic t_loop;
        cfg(8'hFF, 8'h00);
        wd = 8'hC3;
        wstb[0] = 1'b1;
        @(negedge clk);
        wstb[0] = 1'b0;
        rstb[2] = 1'b1;
        @(negedge clk);
        check(rdata, 8'h00);
        @(negedge clk);
        rstb[2] = 1'b0;
        check(rdata, 8'hC3);
        @(negedge clk);
    endtask : t_loop

    // Pin changes just after the latch closed: read data shows it after two and a half cycles, not before
    task automatic t_ext;
        cfg(8'h00, 8'h00);
        ext_en = 8'hFF;
        ext_v = 8'h00;
        repeat (2) @(negedge clk);
        ext_v <= #1 8'h96;
        rstb[2] = 1'b1;
        repeat (2) @(negedge clk);
        check(rdata, 8'h00);
        @(negedge clk);
        check(rdata, 8'h96);
        rstb[2] = 1'b0;
        @(negedge clk);
        ext_en = 8'h00;
    endtask : t_ext

    task automatic t_alt;
        cfg(8'h01, 8'h00);
        alt_en = 8'h80;
        alt_oe = 8'h80;
        alt_v = 8'h80;
        #1;
        check(p_oe, 8'h81);
        check(p_out & 8'h81, 8'h80);
        @(negedge clk);
        alt_en = 8'h00;
        @(negedge clk);
    endtask : t_alt

    task automatic t_rmid;
        cfg(8'hFF, 8'hFF);
        nrst = 1'b0;
        #1;
        check(p_oe, 8'h00);
        check(p_pu, 8'h00);
        @(negedge clk);
        nrst = 1'b1;
        @(negedge clk);
        rd(0, v);
        check(v, 8'h00);
        rd(1, v);
        check(v, 8'h00);
    endtask : t_rmid

    initial begin
        repeat (6) @(negedge clk);
        t_reset;
        t_table;
        t_toggle;
        t_bits;
        t_loop;
        t_ext;
        t_alt;
        t_rmid;
        test_done;
    end

    initial begin
        #20000;
        fails++;
        test_done;
    end
endmodule : tb
`default_nettype wire
